//--- rtl/dtu_consts.svh
// Purpose: constants and permutation tables of the DES / Triple-DES execution unit
// Assumes: DES bit n (1 = leftmost) of a w-bit vector is vector bit w-n
// Notes: definitions only
`ifndef DTU_CONSTS_SVH
`define DTU_CONSTS_SVH

// =====================================================================
// timing and sequencing
`define DTU_LAST_ROUND 4'hF
`define DTU_LAST_PASS_DES 2'h0
`define DTU_MID_PASS 2'h1
`define DTU_LAST_PASS_3DES 2'h2
// rounds 1, 2, 9 and 16 rotate the key halves by one place, the rest by two
`define DTU_SHIFT1_MASK 16'h8103

// =====================================================================
// permutation tables
`define DTU_IP_TAB '{58,50,42,34,26,18,10,2,60,52,44,36,28,20,12,4,62,54,46,38,30,22,14,6,\
64,56,48,40,32,24,16,8,57,49,41,33,25,17,9,1,59,51,43,35,27,19,11,3,61,53,45,37,29,21,13,5,\
63,55,47,39,31,23,15,7}
`define DTU_FP_TAB '{40,8,48,16,56,24,64,32,39,7,47,15,55,23,63,31,38,6,46,14,54,22,62,30,\
37,5,45,13,53,21,61,29,36,4,44,12,52,20,60,28,35,3,43,11,51,19,59,27,34,2,42,10,50,18,58,26,\
33,1,41,9,49,17,57,25}
`define DTU_E_TAB '{32,1,2,3,4,5,4,5,6,7,8,9,8,9,10,11,12,13,12,13,14,15,16,17,16,17,18,19,\
20,21,20,21,22,23,24,25,24,25,26,27,28,29,28,29,30,31,32,1}
`define DTU_P_TAB '{16,7,20,21,29,12,28,17,1,15,23,26,5,18,31,10,2,8,24,14,32,27,3,9,19,13,\
30,6,22,11,4,25}
`define DTU_PC1_TAB '{57,49,41,33,25,17,9,1,58,50,42,34,26,18,10,2,59,51,43,35,27,19,11,3,\
60,52,44,36,63,55,47,39,31,23,15,7,62,54,46,38,30,22,14,6,61,53,45,37,29,21,13,5,28,20,12,4}
`define DTU_PC2_TAB '{14,17,11,24,1,5,3,28,15,6,21,10,23,19,12,4,26,8,16,7,27,20,13,2,41,52,\
31,37,47,55,30,40,51,45,33,48,44,49,39,56,34,53,46,42,50,36,29,32}

// =====================================================================
// substitution boxes, entry (row*16+col) is nibble counted from the left
`define DTU_SBOX_TAB '{\
256'hE4D12FB83A6C59070F74E2D1A6CB953841E8D62BFC973A50FC8249175B3EA06D,\
256'hF18E6B34972DC05A3D47F28EC01A69B50E7BA4D158C6932FD8A13F42B67C05E9,\
256'hA09E63F51DC7B428D709346A285ECBF1D6498F30B12C5AE71AD069874FE3B52C,\
256'h7DE3069A1285BC4FD8B56F03472C1AE9A690CB7DF13E52843F06A1D8945BC72E,\
256'h2C417AB6853FD0E9EB2C47D150FA3986421BAD78F9C5630EB8C71E2D6F09A453,\
256'hC1AF92680D34E75BAF427C9561DE0B389EF528C3704A1DB6432C95FABE17608D,\
256'h4B2EF08D3C975A61D0B7491AE35C2F8614BDC37EAF6805926BD814A7950FE23C,\
256'hD2846FB1A93E50C71FD8A374C56B0E927B419CE206ADF35821E74A8DFC90356B}

`endif

//--- rtl/dtu_pkg.sv
// Purpose: types of the DES / Triple-DES execution unit
// Assumes: nothing beyond SystemVerilog packages
// Notes: carriers are packed structs
package dtu_pkg;

   // =====================================================================
   // modes and states
   typedef enum logic [1:0] {DTU_ECB, DTU_CBC, DTU_TECB, DTU_TCBC} dtu_mode_t;
   typedef enum logic {DTU_IDLE, DTU_RUN} dtu_state_t;

   // =====================================================================
   // carriers
   typedef struct packed {
      logic [63:0] k1;
      logic [63:0] k2;
      logic [63:0] k3;
      logic three_key;
      dtu_mode_t mode;
   } dtu_key_t;

   typedef struct packed {
      logic decrypt;
      logic [63:0] data;
   } dtu_blk_t;

endpackage

//--- rtl/dtu_des_triple_des_unit.sv
// Purpose: des_execution_unit, one DES round per clock, single and triple DES
// Assumes: host loads key and mode, then streams 64-bit blocks; inputs synchronous
// Notes: key parity bits are ignored; result queue of BUF_DEPTH words
`timescale 1ns/1ns
`include "dtu_consts.svh"

module dtu_des_triple_des_unit
   import dtu_pkg::*;
#(
   parameter int BUF_DEPTH = 2
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // session key, mode and start vector
   input wire logic key_load_i,
   input wire dtu_key_t key_i,
   input wire logic iv_load_i,
   input wire logic [63:0] iv_i,
   output logic key_ready_o,
   // input blocks
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire dtu_blk_t in_blk_i,
   // result blocks
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [63:0] out_data_o,
   // status
   output logic busy_o
);

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CW = $clog2(BUF_DEPTH + 1);
   localparam int IP_T [64] = `DTU_IP_TAB;
   localparam int FP_T [64] = `DTU_FP_TAB;
   localparam int E_T [48] = `DTU_E_TAB;
   localparam int P_T [32] = `DTU_P_TAB;
   localparam int PC1_T [56] = `DTU_PC1_TAB;
   localparam int PC2_T [48] = `DTU_PC2_TAB;
   localparam logic [255:0] SBOX [8] = `DTU_SBOX_TAB;
   // a literal cannot be bit-selected, so the shift mask is held as a constant
   localparam logic [15:0] SHIFT1_M = `DTU_SHIFT1_MASK;

   // =====================================================================
   // functions
   function automatic logic [63:0] perm64(input logic [63:0] x, input logic fin);
      logic [63:0] o;
      o = '0;
      for (int i = 0; i < 64; i++)
      begin
         o[63-i] = fin ? x[64-FP_T[i]] : x[64-IP_T[i]];
      end
      return o;
   endfunction

   function automatic logic [55:0] pc1(input logic [63:0] k);
      logic [55:0] o;
      o = '0;
      for (int i = 0; i < 56; i++)
      begin
         o[55-i] = k[64-PC1_T[i]];
      end
      return o;
   endfunction

   function automatic logic [47:0] pc2(input logic [55:0] cd);
      logic [47:0] o;
      o = '0;
      for (int i = 0; i < 48; i++)
      begin
         o[47-i] = cd[56-PC2_T[i]];
      end
      return o;
   endfunction

   // rotate the C and D halves independently
   function automatic logic [55:0] rot(input logic [55:0] cd, input logic two, input logic left);
      logic [27:0] c;
      logic [27:0] d;
      c = cd[55:28];
      d = cd[27:0];
      if (left)
      begin
         c = two ? {c[25:0], c[27:26]} : {c[26:0], c[27]};
         d = two ? {d[25:0], d[27:26]} : {d[26:0], d[27]};
      end
      else
      begin
         c = two ? {c[1:0], c[27:2]} : {c[0], c[27:1]};
         d = two ? {d[1:0], d[27:2]} : {d[0], d[27:1]};
      end
      return {c, d};
   endfunction

   function automatic logic [31:0] feistel(input logic [31:0] r, input logic [47:0] k);
      logic [47:0] x;
      logic [5:0] ch;
      logic [7:0] idx;
      logic [31:0] s;
      logic [31:0] o;
      x = '0;
      s = '0;
      o = '0;
      for (int i = 0; i < 48; i++)
      begin
         x[47-i] = r[32-E_T[i]];
      end
      x = x ^ k;
      for (int b = 0; b < 8; b++)
      begin
         ch = x[47-6*b -: 6];
         idx = {2'h0, ch[5], ch[0], ch[4:1]};
         s[31-4*b -: 4] = SBOX[b][255-4*idx -: 4];
      end
      for (int i = 0; i < 32; i++)
      begin
         o[31-i] = s[32-P_T[i]];
      end
      return o;
   endfunction

   // triple DES runs E-D-E forward and D-E-D backward with keys reversed
   function automatic logic [63:0] pass_key(input dtu_key_t k, input logic [1:0] p,
                                            input logic dec);
      logic [63:0] k3;
      k3 = k.three_key ? k.k3 : k.k1;
      if (p == `DTU_MID_PASS)
      begin
         return k.k2;
      end
      return ((p == `DTU_LAST_PASS_3DES) ^ dec) ? k3 : k.k1;
   endfunction

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(BUF_DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // =====================================================================
   // reset release
   logic [1:0] rst_sync_reg;
   logic rst_n;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   assign rst_n = rst_sync_reg[1];

   // =====================================================================
   // declarations
   dtu_state_t state_reg;
   dtu_key_t key_reg;
   logic key_ready_reg;
   logic [63:0] chain_reg;
   logic [63:0] cin_reg;
   logic dec_reg;
   logic [3:0] round_reg;
   logic [1:0] pass_reg;
   logic [63:0] lr_reg;
   logic [55:0] cd_reg;
   logic [CW-1:0] cnt_reg;
   logic [PW-1:0] wr_reg;
   logic [PW-1:0] rd_reg;
   logic [63:0] mem_reg [BUF_DEPTH];

   logic start;
   logic triple;
   logic cbc;
   logic pass_dec;
   logic [3:0] sched_idx;
   logic [55:0] cd_rot;
   logic [47:0] subkey;
   logic [31:0] f_out;
   logic [63:0] lr_next;
   logic [63:0] res_raw;
   logic [63:0] result;
   logic last_round;
   logic done;
   logic pop;

   assign triple = (key_reg.mode == DTU_TECB) || (key_reg.mode == DTU_TCBC);
   assign cbc = (key_reg.mode == DTU_CBC) || (key_reg.mode == DTU_TCBC);
   // a block is taken only with a key present and a free result slot, so finishing never stalls
   assign in_ready_o = (state_reg == DTU_IDLE) && key_ready_reg
                       && (cnt_reg < CW'(BUF_DEPTH));
   assign start = in_valid_i && in_ready_o;
   assign busy_o = (state_reg == DTU_RUN);
   assign key_ready_o = key_ready_reg;

   // =====================================================================
   // round datapath
   always_comb
   begin
      pass_dec = dec_reg ^ (triple && (pass_reg == `DTU_MID_PASS));
      sched_idx = pass_dec ? (`DTU_LAST_ROUND - round_reg) : round_reg;
      cd_rot = rot(cd_reg, !SHIFT1_M[sched_idx], !pass_dec);
      subkey = pass_dec ? pc2(cd_reg) : pc2(cd_rot);
      f_out = feistel(lr_reg[31:0], subkey);
      last_round = (round_reg == `DTU_LAST_ROUND);
      // last round skips the swap so the next pass starts from this pre-output
      lr_next = last_round ? {lr_reg[63:32] ^ f_out, lr_reg[31:0]}
                           : {lr_reg[31:0], lr_reg[63:32] ^ f_out};
      done = busy_o && last_round
             && (pass_reg == (triple ? `DTU_LAST_PASS_3DES : `DTU_LAST_PASS_DES));
      res_raw = perm64(lr_next, 1'b1);
      result = (cbc && dec_reg) ? (res_raw ^ chain_reg) : res_raw;
   end

   // =====================================================================
   // sequencer
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= DTU_IDLE;
         round_reg <= 4'h0;
         pass_reg <= 2'h0;
         dec_reg <= 1'b0;
         lr_reg <= 64'h0;
         cd_reg <= 56'h0;
         cin_reg <= 64'h0;
      end
      else if (start)
      begin
         state_reg <= DTU_RUN;
         round_reg <= 4'h0;
         pass_reg <= 2'h0;
         dec_reg <= in_blk_i.decrypt;
         cin_reg <= in_blk_i.data;
         lr_reg <= perm64((cbc && !in_blk_i.decrypt) ? (in_blk_i.data ^ chain_reg)
                                                     : in_blk_i.data, 1'b0);
         // single DES always starts from the first key, in either direction
         cd_reg <= pc1(pass_key(key_reg, 2'h0, in_blk_i.decrypt && triple));
      end
      else if (busy_o)
      begin
         lr_reg <= lr_next;
         round_reg <= round_reg + 4'h1;
         if (done)
         begin
            state_reg <= DTU_IDLE;
         end
         else if (last_round)
         begin
            pass_reg <= pass_reg + 2'h1;
            cd_reg <= pc1(pass_key(key_reg, pass_reg + 2'h1, dec_reg));
         end
         else
         begin
            cd_reg <= cd_rot;
         end
      end
   end

   // =====================================================================
   // key, mode and chaining value
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         key_reg <= '0;
         key_ready_reg <= 1'b0;
      end
      else if (key_load_i && !busy_o)
      begin
         key_reg <= key_i;
         key_ready_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         chain_reg <= 64'h0;
      else if (done && cbc)
         chain_reg <= dec_reg ? cin_reg : result;
      else if (iv_load_i && !busy_o)
         chain_reg <= iv_i;
   end

   // =====================================================================
   // result queue; a stalled reader fills it and then closes in_ready_o
   assign pop = out_valid_o && out_ready_i;
   assign out_valid_o = (cnt_reg != '0);
   assign out_data_o = mem_reg[rd_reg];

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= '0;
         wr_reg <= '0;
         rd_reg <= '0;
      end
      else
      begin
         if (done)
            wr_reg <= ptr_inc(wr_reg);
         if (pop)
            rd_reg <= ptr_inc(rd_reg);
         if (done && !pop)
            cnt_reg <= cnt_reg + CW'(1);
         else if (pop && !done)
            cnt_reg <= cnt_reg - CW'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < BUF_DEPTH; i++)
            mem_reg[i] <= 64'h0;
      end
      else if (done)
      begin
         mem_reg[wr_reg] <= result;
      end
   end

endmodule

//--- verification/dtu_unit_sva.sv
// Purpose: concurrent checks on the ports of the des execution unit
// Assumes: one clock domain, reset active low
// Notes: attached by bind from the testbench top file
`timescale 1ns/1ns

module dtu_unit_sva
   import dtu_pkg::*;
#(
   parameter int BUF_DEPTH = 2
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // key and start vector
   input wire logic key_load_i,
   input wire dtu_key_t key_i,
   input wire logic iv_load_i,
   input wire logic [63:0] iv_i,
   input wire logic key_ready_o,
   // blocks in and out
   input wire logic in_valid_i,
   input wire logic in_ready_o,
   input wire dtu_blk_t in_blk_i,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic [63:0] out_data_o,
   input wire logic busy_o
);
   // =====================================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_accept_starts: assert property (in_valid_i && in_ready_o |=> busy_o)
      else $error("accepted block did not start the rounds");
   a_busy_blocks: assert property (busy_o |-> !in_ready_o)
      else $error("input offered ready while rounds run");
   // sixteen rounds at least, for single and triple passes alike
   a_round_min: assert property (in_valid_i && in_ready_o |=> busy_o[*8] ##1 busy_o[*8])
      else $error("rounds ended early");
   a_round_max: assert property (in_valid_i && in_ready_o |-> ##[17:49] !busy_o)
      else $error("rounds ran too long");
   a_done_pushes: assert property ($fell(busy_o) |-> out_valid_o)
      else $error("finished block not offered");
   a_hold_result: assert property (out_valid_o && !out_ready_i
                                   |=> out_valid_o && $stable(out_data_o))
      else $error("result changed before it was read");
   a_out_follows: assert property ($rose(out_valid_o) |-> $fell(busy_o))
      else $error("result offered without a finished block");
   a_key_taken: assert property (key_load_i && !busy_o |=> key_ready_o)
      else $error("key load not acknowledged");
   a_key_sticky: assert property (key_ready_o |=> key_ready_o)
      else $error("key ready dropped");
   a_key_first: assert property (!key_ready_o |-> !in_ready_o)
      else $error("input ready before a key");
endmodule

//--- verification/dtu_host_reader.sv
// Purpose: host side reader of result words
// Assumes: results popped on valid and ready at the rising edge
// Notes: stall_i holds the reader off to fill the result buffer
`timescale 1ns/1ns

module dtu_host_reader
(
   // clock
   input wire logic clk_i,
   // control from the bench
   input wire logic stall_i,
   // result port of the unit
   input wire logic out_valid_i,
   input wire logic [63:0] out_data_i,
   output logic out_ready_o
);
   logic [63:0] got[$];

   initial out_ready_o = 1'b0;

   // =====================================================================
   // read results, changing ready just after the edge
   always @(posedge clk_i)
   begin
      if (out_valid_i && out_ready_o)
         got.push_back(out_data_i);
      out_ready_o <= #1 !stall_i;
   end
endmodule

//--- verification/dtu_des_triple_des_unit_tb.sv
// Purpose: self-checking bench of the des execution unit
// Assumes: known vector key 133457799BBCDFF1, block 0123456789ABCDEF
// Notes: triple forms use equal first and middle keys so single results stay predictable
`timescale 1ns/1ns

module dtu_des_triple_des_unit_tb;
   import dtu_pkg::*;
   localparam logic [63:0] KEY = 64'h133457799BBCDFF1;
   localparam logic [63:0] PT = 64'h0123456789ABCDEF;
   localparam logic [63:0] CT = 64'h85E813540F0AB405;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic key_load_i = 1'b0;
   logic iv_load_i = 1'b0;
   logic in_valid_i = 1'b0;
   logic stall = 1'b0;
   logic [63:0] iv_i = 64'h0;
   dtu_key_t key_i = '0;
   dtu_blk_t in_blk_i = '0;
   logic key_ready_o, in_ready_o, out_valid_o, out_ready_i, busy_o;
   logic [63:0] out_data_o;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;

   dtu_des_triple_des_unit #(.BUF_DEPTH(2)) dtu_des_triple_des_unit_inst (.clk_i(clk_i),
      .arst_n_i(arst_n_i), .key_load_i(key_load_i), .key_i(key_i), .iv_load_i(iv_load_i),
      .iv_i(iv_i), .key_ready_o(key_ready_o), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
      .in_blk_i(in_blk_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
      .out_data_o(out_data_o), .busy_o(busy_o));
   dtu_host_reader dtu_host_reader_inst (.clk_i(clk_i), .stall_i(stall),
      .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_ready_o(out_ready_i));

   // =====================================================================
   // clock, timeout and shared tasks
   initial forever #4 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic load_key(input dtu_mode_t m, input logic three, input logic [63:0] k12,
                           input logic [63:0] k3);
      key_i = '{k1: k12, k2: k12, k3: k3, three_key: three, mode: m};
      key_load_i = 1'b1;
      step(1);
      key_load_i = 1'b0;
   endtask

   task automatic load_iv(input logic [63:0] v);
      iv_i = v;
      iv_load_i = 1'b1;
      step(1);
      iv_load_i = 1'b0;
   endtask

   task automatic send(input logic dec, input logic [63:0] d);
      int w = 0;
      in_blk_i = '{decrypt: dec, data: d};
      in_valid_i = 1'b1;
      while (in_ready_o !== 1'b1 && w < 200)
      begin
         step(1);
         w++;
      end
      if (w == 200)
         n_mismatch++;
      step(1);
      in_valid_i = 1'b0;
   endtask

   task automatic expect_out(input logic [63:0] e);
      int w = 0;
      while (dtu_host_reader_inst.got.size() == 0 && w < 200)
      begin
         step(1);
         w++;
      end
      check(dtu_host_reader_inst.got.size() != 0 ? dtu_host_reader_inst.got.pop_front() : 'x,
            e);
   endtask

   // =====================================================================
   // scenarios
   task automatic t_no_key();
      in_valid_i = 1'b1;
      step(3);
      check(in_ready_o, 64'h0);
      check(busy_o, 64'h0);
      in_valid_i = 1'b0;
   endtask

   task automatic t_ecb();
      load_key(DTU_ECB, 1'b0, KEY, KEY);
      check(key_ready_o, 64'h1);
      send(1'b0, PT);
      step(15);
      check(busy_o, 64'h1);
      step(1);
      check(out_valid_o, 64'h1);
      expect_out(CT);
      send(1'b1, CT);
      expect_out(PT);
   endtask

   task automatic t_triple();
      // two-key form must ignore the third key field
      load_key(DTU_TECB, 1'b0, KEY, 64'hFFFFFFFFFFFFFFFF);
      send(1'b0, PT);
      // a key load while the rounds run must be ignored
      load_key(DTU_ECB, 1'b0, 64'h0, 64'h0);
      step(46);
      check(busy_o, 64'h1);
      step(1);
      check(busy_o, 64'h0);
      expect_out(CT);
      // first and middle keys cancel, so only the third key shows
      load_key(DTU_TECB, 1'b1, 64'hFEDCBA9876543210, KEY);
      send(1'b0, PT);
      expect_out(CT);
      send(1'b1, CT);
      expect_out(PT);
   endtask

   task automatic t_chain(input dtu_mode_t m);
      // single chaining must ignore the third key even in three-key form
      load_key(m, 1'b1, KEY, (m == DTU_CBC) ? 64'hFFFFFFFFFFFFFFFF : KEY);
      load_iv(64'h0);
      send(1'b0, PT);
      // a start vector load while the rounds run must be ignored
      load_iv(64'hFFFFFFFFFFFFFFFF);
      expect_out(CT);
      send(1'b0, PT ^ CT);
      expect_out(CT);
      load_iv(64'h0);
      send(1'b1, CT);
      expect_out(PT);
      send(1'b1, CT);
      expect_out(PT ^ CT);
   endtask

   task automatic t_buffer();
      stall = 1'b1;
      load_key(DTU_ECB, 1'b0, KEY, KEY);
      send(1'b0, PT);
      step(1);
      send(1'b0, PT);
      step(17);
      check(in_ready_o, 64'h0);
      check(out_valid_o, 64'h1);
      stall = 1'b0;
      send(1'b0, PT);
      repeat (3) expect_out(CT);
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      #1;
      arst_n_i = 1'b1;
      step(3);
      t_no_key();
      t_ecb();
      t_triple();
      t_chain(DTU_CBC);
      t_chain(DTU_TCBC);
      t_buffer();
      complete_run();
   end
endmodule

bind dtu_des_triple_des_unit dtu_unit_sva #(.BUF_DEPTH(BUF_DEPTH)) dtu_unit_sva_inst (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .key_load_i(key_load_i), .key_i(key_i),
   .iv_load_i(iv_load_i), .iv_i(iv_i), .key_ready_o(key_ready_o), .in_valid_i(in_valid_i),
   .in_ready_o(in_ready_o), .in_blk_i(in_blk_i), .out_valid_o(out_valid_o),
   .out_ready_i(out_ready_i), .out_data_o(out_data_o), .busy_o(busy_o));
